// [shared/fob_pkg.sv]
package fob_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WP_NS = 70;
    localparam int T_ACC_NS = 150;
    localparam int WP_CYC = ((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                            ((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int ACC_CYC = ((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int SYNC_CYC = 3;
    localparam int RD_WAIT_CYC = ACC_CYC + SYNC_CYC;
    localparam int ADDR_W = 23;
    localparam int BLOCK_LSB = 17;
    localparam int OTP_ADDR_W = 9;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
    localparam logic [7:0] CMD_BUF_PROG = 8'he8;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [8:0] OTP_LOCK_ADDR = 9'h100;
    localparam logic [15:0] OTP_LOCK_VALUE = 16'hfffd;
    localparam int SR_READY_BIT = 7;
    localparam int SR_SEQ_BIT = 5;
    localparam int SR_PERR_BIT = 4;
    localparam int SR_LERR_BIT = 1;
    localparam int XSR_AVAIL_BIT = 7;
    localparam logic [7:0] CNT_MAX_BYTE = 8'h1f;
    localparam logic [7:0] CNT_MAX_WORD = 8'h0f;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_BUF = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam int CTRL_BYTE_BIT = 4;

    typedef enum logic [2:0] {
        OP_NONE, OP_OTP_READ, OP_OTP_PROG, OP_OTP_LOCK, OP_BUF_PROG, OP_CLR_STATUS
    } fob_op_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic byte_n;
    } fob_pins_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [15:0] data;
    } fob_cyc_t;
endpackage

// [hdl/fob_host.sv]
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module fob_host #(
    parameter int BUF_DEPTH = 32,
    parameter logic [7:0] CLR_STATUS_CODE = 8'h50
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output var fob_pkg::fob_pins_t flash_pins,
    input wire logic [15:0] flash_dq_in
);
    localparam int IW = $clog2(BUF_DEPTH);
    localparam int FW = $clog2(BUF_DEPTH + 1);
    localparam int AW = fob_pkg::ADDR_W;
    localparam logic [3:0] WP_LAST = 4'(fob_pkg::WP_CYC - 1);
    localparam logic [3:0] RD_LAST = 4'(fob_pkg::RD_WAIT_CYC - 1);

    if (BUF_DEPTH < 2 || BUF_DEPTH > 32) begin : g_depth_check
        $error("BUF_DEPTH must lie between 2 and 32");
    end
    if (fob_pkg::RD_WAIT_CYC > 15) begin : g_wait_check
        $error("Read wait does not fit the cycle counter");
    end

    typedef enum {
        S_IDLE, S_ID_CMD, S_ID_READ, S_OTP_SETUP, S_OTP_DATA, S_POLL, S_CLR, S_EXIT,
        S_BUF_CMD, S_BUF_XSR, S_BUF_CNT, S_BUF_DATA, S_BUF_CONF
    } fob_state_t;
    typedef enum {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fob_eph_t;

    function automatic logic [AW-1-fob_pkg::BLOCK_LSB:0] fob_block(input logic [AW-1:0] a);
        return a[AW-1:fob_pkg::BLOCK_LSB];
    endfunction

    function automatic logic [AW-1:0] fob_otp_addr(input logic [AW-1:0] a);
        return {{(AW - fob_pkg::OTP_ADDR_W){1'b0}}, a[fob_pkg::OTP_ADDR_W-1:0]};
    endfunction

    fob_state_t state;
    fob_eph_t eph;
    fob_pkg::fob_op_t op;
    fob_pkg::fob_cyc_t req;
    logic [15:0] dq_s1, dq_s2, dq_s3;
    logic [3:0] ecnt;
    logic ewr;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic cyc_go;
    logic pend;
    logic byte_mode;
    logic [AW-1:0] op_addr, cur_addr, last_addr;
    logic [15:0] op_data, rd_value;
    logic [15:0] buf_mem [BUF_DEPTH];
    logic [FW-1:0] fill;
    logic [IW-1:0] idx;
    logic [7:0] cnt_lim, last_status;
    logic busy, done, refused, unaligned, perr, lerr, seq_err;
    logic start;
    fob_pkg::fob_op_t next_op;
    logic next_refuse;

    // Three-stage pin synchroniser; only the last two are compared
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dq_s1 <= 16'h0000;
            dq_s2 <= 16'h0000;
            dq_s3 <= 16'h0000;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
        end
    end

    // Bus cycle engine; two cycles of chip enable high between cycles
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            eph <= E_IDLE;
            ecnt <= 4'h0;
            ewr <= 1'b0;
            cyc_done <= 1'b0;
            cyc_rdata <= 16'h0000;
            flash_pins <= '{addr: '0, dq_out: 16'h0000, dq_oe: 1'b0, ce_n: 1'b1,
                            oe_n: 1'b1, we_n: 1'b1, byte_n: 1'b1};
        end else begin
            cyc_done <= 1'b0;
            case (eph)
                E_IDLE: begin
                    if (cyc_go) begin
                        flash_pins.addr <= req.addr;
                        flash_pins.dq_out <= req.data;
                        flash_pins.dq_oe <= req.wr;
                        flash_pins.ce_n <= 1'b0;
                        flash_pins.byte_n <= ~byte_mode;
                        ewr <= req.wr;
                        eph <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    ecnt <= 4'h0;
                    eph <= E_STROBE;
                    if (ewr) begin
                        flash_pins.we_n <= 1'b0;
                    end else begin
                        flash_pins.oe_n <= 1'b0;
                    end
                end
                E_STROBE: begin
                    if (ewr ? (ecnt != WP_LAST) : (ecnt != RD_LAST)) begin
                        ecnt <= ecnt + 4'h1;
                    end
                    if (ewr && ecnt == WP_LAST) begin
                        flash_pins.we_n <= 1'b1;
                        eph <= E_HOLD;
                    end
                    // Wait for a settled bus; each read ends with output enable high
                    if (!ewr && ecnt == RD_LAST && dq_s2 == dq_s3) begin
                        cyc_rdata <= dq_s3;
                        flash_pins.oe_n <= 1'b1;
                        eph <= E_HOLD;
                    end
                end
                E_HOLD: begin
                    flash_pins.ce_n <= 1'b1;
                    flash_pins.dq_oe <= 1'b0;
                    cyc_done <= 1'b1;
                    eph <= E_IDLE;
                end
                default: eph <= E_IDLE;
            endcase
        end
    end

    assign cyc_go = (state != S_IDLE) && !pend;
    assign cnt_lim = byte_mode ? fob_pkg::CNT_MAX_BYTE : fob_pkg::CNT_MAX_WORD;

    always_comb begin
        req = '0;
        case (state)
            S_ID_CMD: begin
                req.wr = 1'b1;
                req.addr = fob_otp_addr(op_addr);
                req.data = {8'h00, fob_pkg::CMD_READ_ID};
            end
            S_ID_READ: begin
                req.addr = fob_otp_addr(op_addr);
            end
            S_OTP_SETUP: begin
                req.wr = 1'b1;
                req.addr = fob_otp_addr(op_addr);
                req.data = {8'h00, fob_pkg::CMD_OTP_SETUP};
            end
            S_OTP_DATA: begin
                req.wr = 1'b1;
                req.addr = fob_otp_addr(op_addr);
                req.data = op_data;
            end
            S_POLL: begin
                req.addr = (op == fob_pkg::OP_BUF_PROG) ? op_addr : fob_otp_addr(op_addr);
            end
            S_CLR: begin
                req.wr = 1'b1;
                req.data = {8'h00, CLR_STATUS_CODE};
            end
            S_EXIT: begin
                req.wr = 1'b1;
                req.data = {8'h00, fob_pkg::CMD_READ_ARRAY};
            end
            S_BUF_CMD: begin
                req.wr = 1'b1;
                req.addr = op_addr;
                req.data = {8'h00, fob_pkg::CMD_BUF_PROG};
            end
            S_BUF_XSR: begin
                req.addr = op_addr;
            end
            S_BUF_CNT: begin
                req.wr = 1'b1;
                req.addr = op_addr;
                req.data = 16'(fill - FW'(1));
            end
            S_BUF_DATA: begin
                req.wr = 1'b1;
                req.addr = cur_addr;
                req.data = buf_mem[idx];
            end
            S_BUF_CONF: begin
                req.wr = 1'b1;
                req.addr = op_addr;
                req.data = {8'h00, fob_pkg::CMD_CONFIRM};
            end
            default: req = '0;
        endcase
    end

    // Start checks: whole burst must stay in one block and fit the count
    always_comb begin
        last_addr = op_addr;
        next_op = fob_pkg::fob_op_t'(sw_wdata[2:0]);
        start = sw_wr && sw_addr == fob_pkg::REG_CTRL && state == S_IDLE;
        last_addr = sw_wdata[fob_pkg::CTRL_BYTE_BIT] ? AW'(fill - FW'(1)) : AW'({fill - FW'(1), 1'b0});
        last_addr = AW'(op_addr + last_addr);
        next_refuse = 1'b0;
        if (next_op == fob_pkg::OP_BUF_PROG) begin
            next_refuse = fill == '0 ||
                8'(fill - FW'(1)) > (sw_wdata[fob_pkg::CTRL_BYTE_BIT] ? fob_pkg::CNT_MAX_BYTE
                                                                      : fob_pkg::CNT_MAX_WORD) ||
                fob_block(last_addr) != fob_block(op_addr);
        end else if (next_op == fob_pkg::OP_NONE || next_op > fob_pkg::OP_CLR_STATUS) begin
            next_refuse = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= S_IDLE;
            op <= fob_pkg::OP_NONE;
            pend <= 1'b0;
            byte_mode <= 1'b0;
            cur_addr <= '0;
            idx <= '0;
            rd_value <= 16'h0000;
            last_status <= 8'h00;
            {done, refused, unaligned, perr, lerr, seq_err} <= 6'h00;
        end else begin
            if (cyc_go) begin
                pend <= 1'b1;
            end else if (cyc_done) begin
                pend <= 1'b0;
            end
            if (start) begin
                {done, refused, unaligned, perr, lerr, seq_err} <= 6'h00;
                op <= next_op;
                byte_mode <= sw_wdata[fob_pkg::CTRL_BYTE_BIT];
                cur_addr <= op_addr;
                idx <= '0;
                unaligned <= next_op == fob_pkg::OP_BUF_PROG && op_addr[4:0] != 5'h00;
                if (next_refuse) begin
                    refused <= 1'b1;
                    done <= 1'b1;
                end else begin
                    case (next_op)
                        fob_pkg::OP_OTP_READ: state <= S_ID_CMD;
                        fob_pkg::OP_BUF_PROG: state <= S_BUF_CMD;
                        fob_pkg::OP_CLR_STATUS: state <= S_CLR;
                        default: state <= S_OTP_SETUP;
                    endcase
                end
            end else if (cyc_done) begin
                case (state)
                    S_ID_CMD: state <= S_ID_READ;
                    S_ID_READ: begin
                        rd_value <= cyc_rdata;
                        state <= S_EXIT;
                    end
                    S_OTP_SETUP: state <= S_OTP_DATA;
                    S_OTP_DATA: state <= S_POLL;
                    S_POLL: begin
                        // Every poll is a fresh read; the status is kept only from a read with the ready bit set
                        if (cyc_rdata[fob_pkg::SR_READY_BIT]) begin
                            last_status <= cyc_rdata[7:0];
                            perr <= cyc_rdata[fob_pkg::SR_PERR_BIT];
                            lerr <= cyc_rdata[fob_pkg::SR_LERR_BIT];
                            seq_err <= cyc_rdata[fob_pkg::SR_PERR_BIT] & cyc_rdata[fob_pkg::SR_SEQ_BIT];
                            if (cyc_rdata[fob_pkg::SR_PERR_BIT] || cyc_rdata[fob_pkg::SR_LERR_BIT]) begin
                                state <= S_CLR;
                            end else begin
                                state <= S_EXIT;
                            end
                        end
                    end
                    S_CLR: state <= S_EXIT;
                    S_EXIT: begin
                        state <= S_IDLE;
                        done <= 1'b1;
                    end
                    S_BUF_CMD: state <= S_BUF_XSR;
                    S_BUF_XSR: begin
                        state <= cyc_rdata[fob_pkg::XSR_AVAIL_BIT] ? S_BUF_CNT : S_BUF_CMD;
                    end
                    S_BUF_CNT: state <= S_BUF_DATA;
                    S_BUF_DATA: begin
                        idx <= idx + IW'(1);
                        cur_addr <= AW'(cur_addr + (byte_mode ? AW'(1) : AW'(2)));
                        if (FW'(idx) == FW'(fill - FW'(1))) begin
                            state <= S_BUF_CONF;
                        end
                    end
                    S_BUF_CONF: state <= S_POLL;
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Lock operation forces the lock word and its value
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            op_addr <= '0;
            op_data <= 16'h0000;
        end else if (sw_wr && state == S_IDLE && sw_addr == fob_pkg::REG_ADDR) begin
            op_addr <= sw_wdata[AW-1:0];
        end else if (sw_wr && state == S_IDLE && sw_addr == fob_pkg::REG_WDATA) begin
            op_data <= sw_wdata[15:0];
        end else if (start && next_op == fob_pkg::OP_OTP_LOCK) begin
            op_addr <= AW'(fob_pkg::OTP_LOCK_ADDR);
            op_data <= fob_pkg::OTP_LOCK_VALUE;
        end
    end

    // Buffer fills only while idle; emptied when a burst ends or is refused
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fill <= '0;
        end else if ((start && next_op == fob_pkg::OP_BUF_PROG && next_refuse) ||
                     (state == S_EXIT && cyc_done && op == fob_pkg::OP_BUF_PROG)) begin
            fill <= '0;
        end else if (sw_wr && sw_addr == fob_pkg::REG_BUF && state == S_IDLE && fill != FW'(BUF_DEPTH)) begin
            buf_mem[fill[IW-1:0]] <= sw_wdata[15:0];
            fill <= fill + FW'(1);
        end
    end

    assign busy = state != S_IDLE;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sw_rdata <= 32'h0000_0000;
        end else if (sw_rd && sw_addr == fob_pkg::REG_STATUS) begin
            sw_rdata <= {8'h00, 8'(fill), last_status, 1'b0, seq_err, lerr, perr, unaligned, refused, done, busy};
        end else if (sw_rd && sw_addr == fob_pkg::REG_RDATA) begin
            sw_rdata <= {16'h0000, rd_value};
        end else if (sw_rd && sw_addr == fob_pkg::REG_ADDR) begin
            sw_rdata <= 32'(op_addr);
        end else if (sw_rd && sw_addr == fob_pkg::REG_WDATA) begin
            sw_rdata <= {16'h0000, op_data};
        end else begin
            sw_rdata <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_id_exit_next: assert property ((state == S_ID_READ && cyc_done) |=> state == S_EXIT)
        else $error("Identification read not followed by exit");
    a_id_cmd_code: assert property ((state == S_ID_CMD && !flash_pins.we_n) |->
        flash_pins.dq_out[7:0] == fob_pkg::CMD_READ_ID) else $error("Wrong identifier command");
    a_setup_pair: assert property ((state == S_OTP_SETUP && cyc_done) |=>
        state == S_OTP_DATA ##[1:12] !flash_pins.we_n) else $error("Setup not followed by data write");
    a_lock_value: assert property ((state == S_OTP_DATA && op == fob_pkg::OP_OTP_LOCK && !flash_pins.we_n) |->
        flash_pins.dq_out == fob_pkg::OTP_LOCK_VALUE && flash_pins.addr == AW'(fob_pkg::OTP_LOCK_ADDR))
        else $error("Lock write has wrong address or value");
    a_otp_upper_zero: assert property ((state inside {S_ID_READ, S_OTP_SETUP, S_OTP_DATA} && !flash_pins.ce_n) |->
        flash_pins.addr[AW-1:fob_pkg::OTP_ADDR_W] == '0) else $error("Upper address lines not zero");
    a_xsr_retry: assert property ((state == S_BUF_XSR && cyc_done && !cyc_rdata[7]) |=>
        state == S_BUF_CMD) else $error("Buffer command not repeated");
    a_count_range: assert property ((state == S_BUF_CNT && !flash_pins.we_n) |->
        flash_pins.dq_out[7:0] <= cnt_lim && flash_pins.dq_out[15:8] == 8'h00) else $error("Count out of range");
    a_same_block: assert property ((state == S_BUF_DATA && !flash_pins.ce_n) |->
        fob_block(flash_pins.addr) == fob_block(op_addr)) else $error("Buffer data outside block");
    a_confirm_code: assert property ((state == S_BUF_CONF && !flash_pins.we_n) |->
        flash_pins.dq_out[7:0] == fob_pkg::CMD_CONFIRM) else $error("Wrong confirm code");
    a_exit_code: assert property ((state == S_EXIT && !flash_pins.we_n) |->
        flash_pins.dq_out[7:0] == fob_pkg::CMD_READ_ARRAY) else $error("Wrong read-array code");

    c_otp_read: cover property (state == S_ID_READ && cyc_done);
    c_buf_retry: cover property (state == S_BUF_XSR && cyc_done && !cyc_rdata[7]);
    c_lock_done: cover property (state == S_EXIT && op == fob_pkg::OP_OTP_LOCK && cyc_done);
    c_err_clear: cover property (state == S_CLR && op == fob_pkg::OP_BUF_PROG && cyc_done);
endmodule
`default_nettype wire

// [tb/fob_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fob_flash_model #(
    parameter logic [7:0] CLR_CODE = 8'h50
) (
    input wire fob_pkg::fob_pins_t pins,
    output logic [15:0] dq
);
    logic [7:0] ob [0:17];
    logic [7:0] sr;
    logic [2:0] md;
    logic [7:0] left;
    logic [5:0] blk;
    logic [15:0] val;
    logic [22:0] bstart;
    logic [8:0] ix;
    logic [8:0] rx;
    logic av;
    int waits;
    int e8n;
    int bcnt;
    initial begin
        for (int i = 0; i < 18; i++) ob[i] = (i >= 2 && i < 10) ? 8'(8'h10 + i) : 8'hff;
        ob[0] = 8'hfe;
        sr = 8'h00;
        md = 3'd0;
        av = 1'b1;
        waits = 0;
        e8n = 0;
        bcnt = 0;
        val = 16'h0000;
    end
    // Not driven: inverse of last value, so stale data cannot pass
    assign dq = (!pins.ce_n && !pins.oe_n) ? val : ~val;
    always @(posedge pins.we_n) begin
        if (!pins.ce_n) begin
            ix = {pins.addr[8:1], pins.addr[0] & !pins.byte_n} - 9'h100;
            case (md)
                3'd4: begin
                    md = 3'd2;
                    waits = 2;
                    if (pins.addr[22:9] != 0 || ix > 17 || ix == 1) sr[4] = 1'b1;
                    else if ((ix >= 2 && ix < 10) || !ob[0][1]) sr[4:1] = 4'b1001;
                    else begin
                        ob[ix] = ob[ix] & pins.dq_out[7:0];
                        if (pins.byte_n) ob[ix+1] = ob[ix+1] & pins.dq_out[15:8];
                    end
                end
                3'd5: begin
                    if (bcnt == 0) bstart = pins.addr;
                    bcnt++;
                    if (pins.addr[22:17] != blk) begin
                        sr[5:4] = 2'b11;
                        md = 3'd2;
                    end else if (left == 0) md = 3'd6;
                    else left--;
                end
                3'd6: begin
                    md = 3'd2;
                    if (pins.dq_out[7:0] == fob_pkg::CMD_CONFIRM) waits = 3;
                    else sr[5:4] = 2'b11;
                end
                default: begin
                    if (md == 3'd3 && pins.dq_out[7:0] != fob_pkg::CMD_BUF_PROG) begin
                        left = pins.dq_out[7:0];
                        blk = pins.addr[22:17];
                        bcnt = 0;
                        md = 3'd5;
                    end else begin
                        md = 3'd2;
                        case (pins.dq_out[7:0])
                            fob_pkg::CMD_READ_ID: md = 3'd1;
                            fob_pkg::CMD_READ_ARRAY: md = 3'd0;
                            fob_pkg::CMD_OTP_SETUP: md = 3'd4;
                            fob_pkg::CMD_BUF_PROG: begin
                                md = 3'd3;
                                av = ~av;
                                e8n++;
                            end
                            CLR_CODE: sr = 8'h00;
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end
    // Status is sampled again on each output-enable fall
    always @(negedge pins.oe_n) begin
        rx = {pins.addr[8:1], pins.addr[0] & !pins.byte_n} - 9'h100;
        if (md == 3'd1) val = pins.byte_n ? {ob[rx+1], ob[rx]} : {8'h00, ob[rx]};
        else if (md == 3'd3) val = {8'h00, av, 7'h00};
        else if (md == 3'd0) val = pins.addr[15:0] ^ 16'h5a5a;
        else begin
            if (waits > 0) waits--;
            val = {8'h00, waits == 0, sr[6:0]};
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, sys_rst, sw_wr, sw_rd;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, s;
    logic [15:0] flash_dq_in;
    fob_pkg::fob_pins_t flash_pins;
    int bad_count, comparisons;
    fob_host dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
    fob_flash_model model (.pins(flash_pins), .dq(flash_dq_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        @(posedge clk_sys);
        d = sw_rdata;
    endtask
    // Polls done or refused; bounded so a stuck op still ends
    task automatic run(input logic [2:0] op, input logic bm, input logic [22:0] a);
        wr(fob_pkg::REG_ADDR, {9'h000, a});
        wr(fob_pkg::REG_CTRL, {27'h0, bm, 1'b0, op});
        s = 32'h0;
        for (int i = 0; i < 3000 && s[1] !== 1'b1 && s[2] !== 1'b1; i++) rd(fob_pkg::REG_STATUS, s);
        check({31'h0, s[1]}, 32'h1);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #5000000;
        bad_count++;
        $display("[ERR] %0t ns: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        sys_rst = 1'b1;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        sw_addr = 8'h00;
        sw_wdata = 32'h0;
        bad_count = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rd(fob_pkg::REG_STATUS, s);
        check(s, 32'h0);
        rd(8'hfc, s);
        check(s, 32'h0);
        $display("test reset done");
        run(3'd1, 1'b0, 23'h102);
        rd(fob_pkg::REG_RDATA, s);
        check(s, 32'h1312);
        run(3'd1, 1'b0, 23'h103);
        rd(fob_pkg::REG_RDATA, s);
        check(s, 32'h1312);
        run(3'd1, 1'b1, 23'h109);
        rd(fob_pkg::REG_RDATA, s);
        check({24'h0, s[7:0]}, 32'h19);
        check({29'h0, model.md}, 32'h0);
        $display("test protection read done");
        wr(fob_pkg::REG_WDATA, 32'h1234);
        run(3'd2, 1'b0, 23'h10a);
        check(s & 32'h7f, 32'h02);
        run(3'd1, 1'b0, 23'h10a);
        rd(fob_pkg::REG_RDATA, s);
        check(s, 32'h1234);
        wr(fob_pkg::REG_WDATA, 32'h0);
        run(3'd2, 1'b0, 23'h102);
        check(s & 32'h7f, 32'h32);
        run(3'd5, 1'b0, 23'h0);
        check(s & 32'h7f, 32'h02);
        run(3'd2, 1'b0, 23'h124);
        check(s & 32'h7f, 32'h12);
        run(3'd5, 1'b0, 23'h0);
        $display("test protection program done");
        run(3'd3, 1'b0, 23'h0);
        check(s & 32'h7f, 32'h02);
        rd(fob_pkg::REG_ADDR, s);
        check(s, 32'h100);
        rd(fob_pkg::REG_WDATA, s);
        check(s, 32'hfffd);
        run(3'd2, 1'b0, 23'h10c);
        check(s & 32'h7f, 32'h32);
        run(3'd5, 1'b0, 23'h0);
        run(3'd1, 1'b0, 23'h10c);
        rd(fob_pkg::REG_RDATA, s);
        check(s, 32'hffff);
        run(3'd1, 1'b0, 23'h100);
        rd(fob_pkg::REG_RDATA, s);
        check(s, 32'hfffc);
        $display("test protection lock done");
        for (int i = 0; i < 3; i++) wr(fob_pkg::REG_BUF, 32'h0a01 + i);
        run(3'd4, 1'b0, 23'h020000);
        check(s & 32'h7f, 32'h02);
        check(32'(model.e8n), 32'd2);
        check(32'(model.bcnt), 32'd3);
        check({9'h0, model.bstart}, 32'h020000);
        wr(fob_pkg::REG_BUF, 32'h5555);
        run(3'd4, 1'b0, 23'h020002);
        check(s & 32'h7f, 32'h0a);
        for (int i = 0; i < 16; i++) wr(fob_pkg::REG_BUF, 32'h1000 + i);
        run(3'd4, 1'b0, 23'h040000);
        check(s & 32'h7f, 32'h02);
        check(32'(model.bcnt), 32'd16);
        for (int i = 0; i < 17; i++) wr(fob_pkg::REG_BUF, 32'h2000 + i);
        run(3'd4, 1'b0, 23'h040000);
        check({31'h0, s[2]}, 32'h1);
        for (int i = 0; i < 2; i++) wr(fob_pkg::REG_BUF, 32'h3000 + i);
        run(3'd4, 1'b0, 23'h03fffe);
        check({31'h0, s[2]}, 32'h1);
        check(32'(model.e8n), 32'd6);
        check({29'h0, model.md}, 32'h0);
        for (int i = 0; i < 2; i++) wr(fob_pkg::REG_BUF, 32'h0040 + i);
        run(3'd4, 1'b1, 23'h060000);
        check(s & 32'h7f, 32'h02);
        check(32'(model.bcnt), 32'd2);
        check({9'h0, model.bstart}, 32'h060000);
        check(32'(model.e8n), 32'd8);
        $display("test buffer program done");
        end_of_test();
    end
endmodule
`default_nettype wire
